//--- shared/mxb_pkg.sv
// Purpose: Shared constants and types for the muxed bus host sideband.
// Assumes: 20 MHz system clock, 400 ns bus clock made here.
// Notes:   Offsets are byte addresses on APB.
package mxb_pkg;
    localparam int CLK_NS        = 50;
    localparam int BUS_PERIOD_NS = 400;
    localparam int HALF_CYC      = BUS_PERIOD_NS / (2 * CLK_NS);
    localparam int DIV_W         = 2;
    localparam int AD_W          = 16;
    localparam int DRQ_W         = 8;
    localparam int DRQ_RSVD      = 4;
    localparam int SYNC_STAGES   = 2;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ    = 8'h08;
    localparam logic [7:0] OFS_DRQ    = 8'h0C;

    localparam int BIT_GO   = 0;
    localparam int BIT_CC   = 1;
    localparam int BIT_FAST = 4;
    localparam int BIT_WAKE = 5;

    localparam int PH1_BRD  = 15;
    localparam int PH1_STPN = 14;
    localparam int PH1_CC   = 11;
    localparam int PH_IOD   = 1;
    localparam int PH_MIO   = 0;
    localparam int PH2_LEG  = 2;
    localparam int PH2_BHEN = 1;
    localparam int PH2_WR   = 0;

    localparam logic [2:0] CC_RESET = 3'h1;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CFG1, ST_CFG2, ST_CMD, ST_COUNT, ST_STOPPED,
        ST_WAKE, ST_RSWAIT, ST_RSDRV,
        ST_BKSEEN, ST_BKPRE, ST_BKIRQ, ST_BKDRQ, ST_BKEND
    } mxb_state_e;

    typedef struct packed {
        logic       wake;
        logic       fast;
        logic [2:0] clock_count;
        logic       go;
    } mxb_ctrl_s;

    typedef struct packed {
        mxb_state_e       state;
        logic             stopped;
        logic [AD_W-1:0]  irq;
        logic [DRQ_W-1:0] drq;
    } mxb_stat_s;
endpackage

//--- hdl/mxb_sync.sv
// Purpose: Two-stage synchroniser for inputs from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage is visible.
`timescale 1ns/100ps
`default_nettype none
module mxb_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data.
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '1;
            q    <= '1;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

//--- hdl/mxb_apb.sv
// Purpose: APB register slave for the bus host sideband.
// Assumes: Zero wait state slave, one aligned word per register.
// Notes:   Unmapped addresses answer with an error and zero data.
`timescale 1ns/100ps
`default_nettype none
module mxb_apb (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst_n,
    // APB.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // Block side.
    input  wire logic              go_done,
    input  wire logic              wake_done,
    input  wire mxb_pkg::mxb_stat_s stat,
    output var  mxb_pkg::mxb_ctrl_s ctrl
);
    logic acc;
    logic hit;
    logic wr_ctrl;

    assign acc     = psel && penable;
    assign hit     = paddr inside {mxb_pkg::OFS_CTRL, mxb_pkg::OFS_STATUS,
                                   mxb_pkg::OFS_IRQ, mxb_pkg::OFS_DRQ};
    assign wr_ctrl = acc && pwrite && paddr == mxb_pkg::OFS_CTRL;

    // Software sets go and wake; a new set wins over the hardware clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= '{wake: 1'b0, fast: 1'b0, clock_count: mxb_pkg::CC_RESET, go: 1'b0};
        end else begin
            if (wr_ctrl) begin
                ctrl.fast        <= pwdata[mxb_pkg::BIT_FAST];
                ctrl.clock_count <= pwdata[mxb_pkg::BIT_CC +: 3];
            end
            if (wr_ctrl && pwdata[mxb_pkg::BIT_GO]) begin
                ctrl.go <= 1'b1;
            end else if (go_done) begin
                ctrl.go <= 1'b0;
            end
            if (wr_ctrl && pwdata[mxb_pkg::BIT_WAKE]) begin
                ctrl.wake <= 1'b1;
            end else if (wake_done) begin
                ctrl.wake <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    mxb_pkg::OFS_CTRL:   prdata[5:0] <= {ctrl.wake, ctrl.fast, ctrl.clock_count, ctrl.go};
                    mxb_pkg::OFS_STATUS: prdata[4:0] <= {stat.stopped, stat.state};
                    mxb_pkg::OFS_IRQ:    prdata[15:0] <= stat.irq;
                    mxb_pkg::OFS_DRQ:    prdata[7:0] <= stat.drq;
                    default:             prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- hdl/mxb_host.sv
// Purpose: Bus host sideband: stop-clock broadcast, clock restart, IRQ/DRQ drive-back.
// Assumes: This end makes the bus clock by dividing CLOCK.
// Notes:   Ordinary memory, I/O and DMA-acknowledge cycles are not run here.
//
// Function
// - Phase one drives both type bits one
// - Broadcast bit one, stop bit zero
// - Phase one carries three-bit clock count
// - Phase two: fast, 16-bit, write
// - Broadcast strobe on rising edge, one clock
// - Stop clock high after counted edges
// - Host drives line high half clock
// - Claim with address latch low means backoff
// - Abort pending latch phase; block new cycles
// - Precharge lines high, then strobe and backoff
// - Host owns backoff from the strobe, latches IRQs
// - Latch enabled DRQ levels except channel 4, hold, OR
// - Mask DMA requests during drive-back
// - Signal no wait state on claim
// - Legacy timing flag follows the CTRL fast bit
// - Clock halts only after stop broadcast
`timescale 1ns/100ps
`default_nettype none
module mxb_host #(
    parameter int AD_W  = mxb_pkg::AD_W,
    parameter int DRQ_W = mxb_pkg::DRQ_W
) (
    // Clock and reset.
    input  wire logic             CLOCK,
    input  wire logic             NRST,
    // APB.
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [7:0]       PADDR,
    input  wire logic [31:0]      PWDATA,
    output var  logic [31:0]      PRDATA,
    output var  logic             PREADY,
    output var  logic             PSLVERR,
    // Bus pins.
    output var  logic             ATCLK,
    output var  logic             ALE,
    output var  logic             CMD_N,
    output var  logic             NOWS_N,
    output var  logic             LEGACY_TIMING_FLAG,
    input  wire logic [AD_W-1:0]  MUXED_AD_LINES_IN,
    output var  logic [AD_W-1:0]  MUXED_AD_LINES_OUT,
    output var  logic             MUXED_AD_LINES_OE_N,
    input  wire logic             CLAIM_BACKOFF_N_IN,
    output var  logic             CLAIM_BACKOFF_N_OUT,
    output var  logic             CLAIM_BACKOFF_N_OE_N,
    // System side.
    input  wire logic [DRQ_W-1:0] SYS_DRQ,
    output var  logic [AD_W-1:0]  IRQ_OUT,
    output var  logic [DRQ_W-1:0] DRQ_OUT
);
    initial begin
        if (AD_W != 16 || DRQ_W != 8) begin
            $error("mxb_host supports only 16 lines and 8 channels");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers and register slave.

    logic [AD_W-1:0]     mad_s;
    logic                claim_s;
    logic [DRQ_W-1:0]    sdrq_n_s;
    mxb_pkg::mxb_ctrl_s  ctrl;
    mxb_pkg::mxb_stat_s  stat;
    mxb_pkg::mxb_state_e state;
    logic                go_done;
    logic                wake_done;
    logic [DRQ_W-1:0]    drq_lat;

    mxb_sync #(.W(AD_W + 1 + DRQ_W)) u_sync (
        .clk   (CLOCK),
        .rst_n (NRST),
        .d     ({MUXED_AD_LINES_IN, CLAIM_BACKOFF_N_IN, ~SYS_DRQ}),
        .q     ({mad_s, claim_s, sdrq_n_s})
    );

    assign stat = '{state: state, stopped: state == mxb_pkg::ST_STOPPED, irq: IRQ_OUT, drq: drq_lat};

    mxb_apb u_apb (
        .clk       (CLOCK),
        .rst_n     (NRST),
        .psel      (PSEL),
        .penable   (PENABLE),
        .pwrite    (PWRITE),
        .paddr     (PADDR),
        .pwdata    (PWDATA),
        .prdata    (PRDATA),
        .pready    (PREADY),
        .pslverr   (PSLVERR),
        .go_done   (go_done),
        .wake_done (wake_done),
        .stat      (stat),
        .ctrl      (ctrl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus clock divider.

    logic [mxb_pkg::DIV_W-1:0] divcnt;
    logic                      freeze;
    logic                      tick;
    logic                      rise;
    logic                      fall;

    assign freeze = state == mxb_pkg::ST_STOPPED;
    assign tick   = divcnt == mxb_pkg::DIV_W'(mxb_pkg::HALF_CYC - 1);
    assign rise   = tick && !ATCLK && !freeze;
    assign fall   = tick && ATCLK && !freeze;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            divcnt <= '0;
            ATCLK  <= 1'b0;
        end else if (freeze) begin
            divcnt <= '0;
        end else begin
            divcnt <= tick ? '0 : divcnt + 1'b1;
            if (tick) begin
                ATCLK <= !ATCLK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.

    mxb_pkg::mxb_state_e next_state;
    logic [2:0]          cnt;
    logic                bk_req;

    // Claim low with the latch strobe low is a backoff request.
    assign bk_req    = rise && !claim_s && !ALE;
    assign go_done   = state == mxb_pkg::ST_CMD && rise;
    assign wake_done = state == mxb_pkg::ST_WAKE && rise;

    always_comb begin
        next_state = state;
        unique case (state)
            mxb_pkg::ST_IDLE: begin
                if (bk_req) begin
                    next_state = mxb_pkg::ST_BKSEEN;
                end else if (fall && ctrl.go) begin
                    next_state = mxb_pkg::ST_CFG1;
                end
            end
            mxb_pkg::ST_CFG1: begin
                if (bk_req) begin
                    next_state = mxb_pkg::ST_BKSEEN;
                end else if (fall) begin
                    next_state = mxb_pkg::ST_CFG2;
                end
            end
            mxb_pkg::ST_CFG2:    if (rise) next_state = mxb_pkg::ST_CMD;
            mxb_pkg::ST_CMD:     if (rise) next_state = mxb_pkg::ST_COUNT;
            mxb_pkg::ST_COUNT:   if (rise && cnt == 3'h1) next_state = mxb_pkg::ST_STOPPED;
            mxb_pkg::ST_STOPPED: if (!claim_s || ctrl.wake) next_state = mxb_pkg::ST_WAKE;
            mxb_pkg::ST_WAKE:    if (rise) next_state = mxb_pkg::ST_RSWAIT;
            mxb_pkg::ST_RSWAIT:  if (fall) next_state = mxb_pkg::ST_RSDRV;
            mxb_pkg::ST_RSDRV:   if (rise) next_state = mxb_pkg::ST_IDLE;
            mxb_pkg::ST_BKSEEN:  if (fall) next_state = mxb_pkg::ST_BKPRE;
            mxb_pkg::ST_BKPRE:   if (rise) next_state = mxb_pkg::ST_BKIRQ;
            mxb_pkg::ST_BKIRQ:   if (rise) next_state = mxb_pkg::ST_BKDRQ;
            mxb_pkg::ST_BKDRQ:   if (rise) next_state = mxb_pkg::ST_BKEND;
            mxb_pkg::ST_BKEND:   if (fall) next_state = mxb_pkg::ST_IDLE;
            default:             next_state = mxb_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state <= mxb_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Rising edges left before the clock halts; zero counts as eight.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            cnt <= 3'h0;
        end else if (state == mxb_pkg::ST_CMD && rise) begin
            cnt <= ctrl.clock_count;
        end else if (state == mxb_pkg::ST_COUNT && rise) begin
            cnt <= cnt - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            MUXED_AD_LINES_OUT  <= '1;
            MUXED_AD_LINES_OE_N <= 1'b1;
        end else if (next_state == mxb_pkg::ST_CFG1 && state != mxb_pkg::ST_CFG1) begin
            MUXED_AD_LINES_OUT                   <= '0;
            MUXED_AD_LINES_OUT[mxb_pkg::PH1_BRD]  <= 1'b1;
            MUXED_AD_LINES_OUT[mxb_pkg::PH1_STPN] <= 1'b0;
            MUXED_AD_LINES_OUT[mxb_pkg::PH1_CC +: 3] <= ctrl.clock_count;
            MUXED_AD_LINES_OUT[mxb_pkg::PH_IOD]  <= 1'b1;
            MUXED_AD_LINES_OUT[mxb_pkg::PH_MIO]  <= 1'b1;
            MUXED_AD_LINES_OE_N                  <= 1'b0;
        end else if (next_state == mxb_pkg::ST_CFG2 && state == mxb_pkg::ST_CFG1) begin
            MUXED_AD_LINES_OUT[mxb_pkg::PH2_LEG]  <= 1'b1;
            MUXED_AD_LINES_OUT[mxb_pkg::PH2_BHEN] <= 1'b0;
            MUXED_AD_LINES_OUT[mxb_pkg::PH2_WR]   <= 1'b1;
        end else if (next_state == mxb_pkg::ST_BKPRE) begin
            MUXED_AD_LINES_OUT  <= '1;
            MUXED_AD_LINES_OE_N <= 1'b0;
        end else if (next_state inside {mxb_pkg::ST_IDLE, mxb_pkg::ST_COUNT,
                                        mxb_pkg::ST_BKSEEN, mxb_pkg::ST_BKIRQ}) begin
            MUXED_AD_LINES_OE_N <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ALE   <= 1'b0;
            CMD_N <= 1'b1;
        end else begin
            ALE   <= next_state == mxb_pkg::ST_CFG2;
            CMD_N <= !(next_state inside {mxb_pkg::ST_CMD, mxb_pkg::ST_BKIRQ, mxb_pkg::ST_BKDRQ});
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            CLAIM_BACKOFF_N_OUT  <= 1'b1;
            CLAIM_BACKOFF_N_OE_N <= 1'b1;
        end else begin
            unique case (next_state)
                mxb_pkg::ST_RSDRV, mxb_pkg::ST_BKEND: begin
                    CLAIM_BACKOFF_N_OUT  <= 1'b1;
                    CLAIM_BACKOFF_N_OE_N <= 1'b0;
                end
                mxb_pkg::ST_BKIRQ, mxb_pkg::ST_BKDRQ: begin
                    CLAIM_BACKOFF_N_OUT  <= 1'b0;
                    CLAIM_BACKOFF_N_OE_N <= 1'b0;
                end
                default: begin
                    CLAIM_BACKOFF_N_OUT  <= 1'b1;
                    CLAIM_BACKOFF_N_OE_N <= 1'b1;
                end
            endcase
        end
    end

    // No wait state whenever a peripheral claims while the latch strobe is high.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            NOWS_N             <= 1'b1;
            LEGACY_TIMING_FLAG <= 1'b0;
        end else begin
            NOWS_N             <= !(ALE && !claim_s);
            LEGACY_TIMING_FLAG <= ctrl.fast;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive-back capture.

    logic drq_mask;

    assign drq_mask = state inside {mxb_pkg::ST_BKSEEN, mxb_pkg::ST_BKPRE,
                                    mxb_pkg::ST_BKIRQ, mxb_pkg::ST_BKDRQ};

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            IRQ_OUT <= '0;
        end else if (state == mxb_pkg::ST_BKIRQ && rise && !claim_s && !CMD_N) begin
            IRQ_OUT <= ~mad_s;
        end
    end

    genvar g;
    generate
        for (g = 0; g < DRQ_W; g++) begin : g_drq
            always_ff @(posedge CLOCK or negedge NRST) begin
                if (!NRST) begin
                    drq_lat[g] <= 1'b0;
                end else if (state == mxb_pkg::ST_BKDRQ && rise && !mad_s[g + DRQ_W]
                             && g != mxb_pkg::DRQ_RSVD) begin
                    drq_lat[g] <= mad_s[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            DRQ_OUT <= '0;
        end else begin
            DRQ_OUT <= drq_mask || next_state == mxb_pkg::ST_BKSEEN ? '0 : (drq_lat | ~sdrq_n_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_cfg_types;
        @(posedge CLOCK) disable iff (!NRST)
        state == mxb_pkg::ST_CFG1 |-> MUXED_AD_LINES_OUT[1:0] == 2'b11 && !MUXED_AD_LINES_OE_N;
    endproperty
    a_cfg_types: assert property (p_cfg_types) else $error("config type bits wrong");

    property p_cfg_flags;
        @(posedge CLOCK) disable iff (!NRST)
        $rose(ALE) |-> MUXED_AD_LINES_OUT[15:14] == 2'b10
            && MUXED_AD_LINES_OUT[13:11] == ctrl.clock_count;
    endproperty
    a_cfg_flags: assert property (p_cfg_flags) else $error("broadcast flags or count wrong");

    property p_ph2;
        @(posedge CLOCK) disable iff (!NRST)
        $rose(ALE) |-> MUXED_AD_LINES_OUT[2:0] == 3'b101;
    endproperty
    a_ph2: assert property (p_ph2) else $error("phase two bits wrong");

    property p_cmd_len;
        @(posedge CLOCK) disable iff (!NRST)
        $fell(CMD_N) && state == mxb_pkg::ST_CMD |-> !CMD_N [*8] ##1 CMD_N;
    endproperty
    a_cmd_len: assert property (p_cmd_len) else $error("broadcast strobe not one bus clock");

    property p_stop_high;
        @(posedge CLOCK) disable iff (!NRST)
        state == mxb_pkg::ST_STOPPED |-> ATCLK && ($stable(ATCLK) || $past(state) != mxb_pkg::ST_STOPPED);
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("clock not held high");

    property p_stop_cause;
        @(posedge CLOCK) disable iff (!NRST)
        $rose(freeze) |-> $past(state) == mxb_pkg::ST_COUNT;
    endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("clock halted without broadcast");

    property p_rs_half;
        @(posedge CLOCK) disable iff (!NRST)
        $fell(CLAIM_BACKOFF_N_OE_N) && state == mxb_pkg::ST_RSDRV |-> CLAIM_BACKOFF_N_OUT [*4] ##1 CLAIM_BACKOFF_N_OE_N;
    endproperty
    a_rs_half: assert property (p_rs_half) else $error("restart drive not half clock");

    property p_pre;
        @(posedge CLOCK) disable iff (!NRST)
        state == mxb_pkg::ST_BKSEEN && fall |=> (MUXED_AD_LINES_OUT == '1 && !MUXED_AD_LINES_OE_N) [*4] ##1 !CMD_N;
    endproperty
    a_pre: assert property (p_pre) else $error("precharge then strobe wrong");

    property p_mask;
        @(posedge CLOCK) disable iff (!NRST)
        state == mxb_pkg::ST_BKSEEN |=> DRQ_OUT == '0;
    endproperty
    a_mask: assert property (p_mask) else $error("DMA requests not masked");

    property p_drq_hold;
        @(posedge CLOCK) disable iff (!NRST)
        state != mxb_pkg::ST_BKDRQ |=> $stable(drq_lat);
    endproperty
    a_drq_hold: assert property (p_drq_hold) else $error("DRQ level changed outside drive-back");
endmodule
`default_nettype wire

//--- tb/mxb_periph.sv
// Purpose: Behavioural peripheral for drive-back and clock restart.
// Assumes: Muxed lines and the claim line have pull-ups.
// Notes:   A pull bit of one pulls that line low.
`timescale 1ns/100ps
`default_nettype none
module mxb_periph (
    // Bus side.
    input  wire logic        atclk,
    input  wire logic        ale,
    input  wire logic        cmd_n,
    input  wire logic        claim,
    output var  logic [15:0] pull_mad,
    output var  logic        pull_claim,
    // Bench side.
    input  wire logic        req,
    input  wire logic        wake,
    input  wire logic [15:0] irq,
    input  wire logic [15:0] drq,
    output var  logic        busy
);
    int quiet;
    initial begin
        pull_mad = '0;
        pull_claim = 1'b0;
        busy = 1'b0;
    end
    always @(posedge wake) begin
        pull_claim = 1'b1;
        @(posedge atclk);
        pull_claim = 1'b0;
    end
    always @(posedge req) begin
        busy = 1'b1;
        quiet = 0;
        while (quiet < 2) begin
            @(posedge atclk);
            quiet = (claim && cmd_n && !ale) ? quiet + 1 : 0;
        end
        pull_claim = 1'b1;
        do @(negedge atclk); while (cmd_n);
        pull_mad = irq;
        @(posedge atclk);
        pull_claim = 1'b0;
        pull_mad = '0;
        @(negedge atclk);
        pull_mad = ~drq;
        @(posedge atclk);
        pull_mad = '0;
        busy = 1'b0;
    end
endmodule
`default_nettype wire

//--- tb/test_mxb_host.sv
// Purpose: Self-checking bench for the bus host sideband.
// Assumes: Peripheral model on the far side, APB master here.
// Notes:   Random values from a fixed-seed shift register.
`timescale 1ns/100ps
`default_nettype none
module test_mxb_host;
    logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, req = 0, wake = 0, err, prev;
    logic [7:0] paddr = 0, sys = 0, lat = 0, drq_out;
    logic [31:0] pwd = 0, prd, rd, rnd = 32'hB291;
    logic [15:0] mout, muxed_ad_lines, irq = 0, drq = 0, irq_out, pm;
    logic pready, pslv, atclk, ale, cmd_n, nows, leg, moe_n, cout, coe_n, claim, pc, busy;
    logic [2:0] cc;
    int n_mismatch = 0, compares = 0, n, r, h;
    assign muxed_ad_lines = moe_n ? ~pm : mout;
    assign claim = (coe_n | cout) & ~pc;
    mxb_host DUT (.CLOCK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(pslv), .ATCLK(atclk), .ALE(ale),
        .CMD_N(cmd_n), .NOWS_N(nows), .LEGACY_TIMING_FLAG(leg), .MUXED_AD_LINES_IN(muxed_ad_lines),
        .MUXED_AD_LINES_OUT(mout), .MUXED_AD_LINES_OE_N(moe_n), .CLAIM_BACKOFF_N_IN(claim),
        .CLAIM_BACKOFF_N_OUT(cout), .CLAIM_BACKOFF_N_OE_N(coe_n), .SYS_DRQ(sys), .IRQ_OUT(irq_out),
        .DRQ_OUT(drq_out));
    mxb_periph PER (.atclk(atclk), .ale(ale), .cmd_n(cmd_n), .claim(claim), .pull_mad(pm),
        .pull_claim(pc), .req(req), .wake(wake), .irq(irq), .drq(drq), .busy(busy));
    initial begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] drq_exp(input logic [7:0] old, en_n, lv);
        logic [7:0] en;
        en = ~en_n & 8'hEF;
        return (old & ~en) | (lv & en);
    endfunction
    task automatic close_out;
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wt(ref logic s, input logic v, input int lim);
        int k = 0;
        while (s !== v && k < lim) begin
            @(posedge clk);
            k++;
        end
        if (s !== v) begin
            n_mismatch++;
            close_out;
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k = 0;
        psel <= 1;
        pwr <= wr;
        paddr <= a;
        pwd <= wd;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prd;
        err = pslv;
        psel <= 0;
        pen <= 0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            close_out;
        end
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        apb(0, 8'h00, 0);
        chk(rd, 32'h2);
        chk({irq_out, drq_out}, 0);
        apb(0, 8'h10, 0);
        chk(err, 1);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            cc = (i == 0) ? 3'h1 : (i == 1) ? 3'h0 : rnd[2:0];
            apb(1, 8'h00, {27'h0, i[0], cc, 1'b1});
            wt(moe_n, 0, 100);
            chk({mout[15:11], mout[1:0]}, {2'b10, cc, 2'b11});
            wt(ale, 1, 100);
            chk({mout[15:11], mout[2:0], leg, nows}, {2'b10, cc, 3'b101, i[0], 1'b1});
            wt(cmd_n, 0, 100);
            n = 0;
            while (cmd_n === 1'b0 && n < 20) begin
                @(posedge clk);
                n++;
            end
            chk(n, 8);
            {r, h, n, prev} = {32'd0, 32'd0, 32'd0, atclk};
            while (h < 12 && n < 200) begin
                @(posedge clk);
                r += (atclk && !prev);
                h = atclk ? h + 1 : 0;
                prev = atclk;
                n++;
            end
            chk(r, (cc == 0) ? 32'd8 : 32'(cc));
            chk(atclk, 1);
            if (i == 1) apb(1, 8'h00, 32'h20);
            else wake <= 1;
            wt(coe_n, 0, 200);
            chk(cout, 1);
            wake <= 0;
            wt(coe_n, 1, 50);
        end
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            irq <= rnd[15:0];
            drq <= (i == 0) ? 16'h00FF : rnd[31:16];
            sys <= (i == 3) ? rnd[27:20] : 8'h0;
            req <= 1;
            wt(moe_n, 0, 400);
            chk(mout, 16'hFFFF);
            wt(cmd_n, 0, 50);
            chk({drq_out, coe_n, cout}, 0);
            wt(busy, 0, 100);
            req <= 0;
            wt(cmd_n, 1, 50);
            wt(coe_n, 1, 50);
            repeat (4) @(posedge clk);
            lat = drq_exp(lat, drq[15:8], drq[7:0]);
            chk({irq_out, drq_out}, {irq, lat | sys});
            apb(0, 8'h0C, 0);
            chk(rd, {24'h0, lat});
        end
        close_out;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        close_out;
    end
endmodule
`default_nettype wire
